/* File: hdl/iefc_ctrl.sv */
// Interrupt enable and flag controller with a Wishbone register slave.
// Assumes pulse and level inputs synchronous to clk_i.
//
// Operation
// - Flags set on their event regardless of any enable bit.
// - Control bit 7 is global enable; zero blocks every request to the core, not irq_o.
// - Control bit 6 gates all peripheral sources together.
// - Control bit 5 enables the timer-0 overflow source.
// - Control bit 4 enables the external pin edge source.
// - Control bit 3 enables the upper-nibble port-change source.
// - Control bit 2 sets on timer-0 overflow, only software clears.
// - Control bit 1 sets on external pin event, software clears.
// - Control bit 0 sets when an upper port pin changed.
// - Mismatch keeps setting port flag; reading port relatches pins.
// - Peripheral enable register, seven enables, top bit reads zero.
// - Peripheral flag register uses same bit positions as enables.
// - Control register reachable at same offset in all four banks.
// - Peripheral flag register sits at one lowest-bank address.
// - Receive flag follows buffer full, transmit flag buffer empty.
`default_nettype none
module iefc_ctrl (
	input  wire logic        clk_i,             // Core clock
	input  wire logic        rst_i,             // Sync reset, high
	input  wire logic        cyc_i,             // Bus cycle
	input  wire logic        stb_i,             // Bus strobe
	input  wire logic        we_i,              // Write enable
	input  wire logic [10:0] adr_i,             // Byte address
	input  wire logic [3:0]  sel_i,             // Byte lanes
	input  wire logic [31:0] dat_i,             // Write data
	output logic      [31:0] dat_o,             // Read data
	output logic             ack_o,             // Bus acknowledge
	input  wire logic        timer0_overflow_i, // Overflow pulse
	input  wire logic        ext_pin_edge_i,    // Selected edge pulse
	input  wire logic [3:0]  upper_port_nibble_i, // Upper port pins
	input  wire logic        converter_done_i,  // Pulse
	input  wire logic        serial_rx_full_i,  // Level
	input  wire logic        serial_tx_empty_i, // Level
	input  wire logic        sync_serial_i,     // Pulse
	input  wire logic        capcmp_i,          // Pulse
	input  wire logic        timer2_match_i,    // Pulse
	input  wire logic        timer1_overflow_i, // Pulse
	output logic             core_irq_req_o,    // Request to core
	output logic             irq_o              // Masked event summary
);
	// ****************************************
	// Bus decode
	// ****************************************
	logic             ack_ff;
	logic [31:0]      rd_data_ff;
	logic [8:0]       idx;
	logic             bus_req;
	logic             wr_lane0;
	logic             rd_req;
	logic             hit_ctrl;
	logic             hit_pie;
	logic             hit_pir;
	logic             hit_port;
	logic             hit_stat;
	logic             hit_mask;

	assign idx      = adr_i[10:2];
	assign bus_req  = cyc_i & stb_i & ~ack_ff;
	assign wr_lane0 = bus_req & we_i & sel_i[0];
	assign rd_req   = bus_req & ~we_i;
	assign hit_ctrl = (idx == iefc_pkg::IDX_CTRL_BANK0) |
		(idx == iefc_pkg::IDX_CTRL_BANK1) |
		(idx == iefc_pkg::IDX_CTRL_BANK2) |
		(idx == iefc_pkg::IDX_CTRL_BANK3);
	assign hit_pie  = idx == iefc_pkg::IDX_PIE_ONE;
	assign hit_pir  = idx == iefc_pkg::IDX_PIR_ONE;
	assign hit_port = idx == iefc_pkg::IDX_PORT;
	assign hit_stat = idx == iefc_pkg::IDX_EVT_STAT;
	assign hit_mask = idx == iefc_pkg::IDX_EVT_MASK;

	// ****************************************
	// Core control register
	// ****************************************
	logic [4:0]       core_en_ff;
	logic [2:0]       core_flag_ff;
	logic [2:0]       nxt_core_flag;
	logic [2:0]       core_evt;
	logic [3:0]       nibble_latch_ff;
	logic             latch_live_ff;
	logic             mismatch;

	// Latch empty until the first cycle after reset to avoid a false change
	assign mismatch = latch_live_ff &
		(upper_port_nibble_i != nibble_latch_ff);
	assign core_evt = {timer0_overflow_i, ext_pin_edge_i, mismatch};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			core_en_ff <= iefc_pkg::RST_CORE_EN;
		end else if (wr_lane0 && hit_ctrl) begin
			core_en_ff <= dat_i[7:3];
		end
	end

	// Event wins over a write of zero in the same cycle
	always_comb begin
		nxt_core_flag = core_flag_ff;
		if (wr_lane0 && hit_ctrl) begin
			nxt_core_flag = dat_i[2:0];
		end
		nxt_core_flag = nxt_core_flag | core_evt;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			core_flag_ff <= iefc_pkg::RST_CORE_FLAG;
		end else begin
			core_flag_ff <= nxt_core_flag;
		end
	end

	// Port read relatches pins, ending the mismatch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nibble_latch_ff <= iefc_pkg::RST_NIBBLE;
			latch_live_ff   <= 1'b0;
		end else if (!latch_live_ff || (rd_req && hit_port)) begin
			nibble_latch_ff <= upper_port_nibble_i;
			latch_live_ff   <= 1'b1;
		end
	end

	// ****************************************
	// Peripheral enables and flags
	// ****************************************
	logic [6:0]       pie_ff;
	logic [6:0]       pir_flag;
	logic [6:0]       peri_evt;
	logic [6:0]       peri_lvl;

	assign peri_evt = {converter_done_i, 2'b00, sync_serial_i, capcmp_i,
		timer2_match_i, timer1_overflow_i};
	assign peri_lvl = {1'b0, serial_rx_full_i, serial_tx_empty_i, 4'h0};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pie_ff <= iefc_pkg::RST_PERI;
		end else if (wr_lane0 && hit_pie) begin
			pie_ff <= dat_i[6:0];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < iefc_pkg::PERI_N; gi++) begin : g_pir
			if (iefc_pkg::PIR_LEVEL_MASK[gi]) begin : g_lvl
				// Cleared by the serial unit's own buffer access
				assign pir_flag[gi] = peri_lvl[gi];
			end else begin : g_sticky
				logic flag_ff;
				always_ff @(posedge clk_i) begin
					if (rst_i) begin
						flag_ff <= 1'b0;
					end else if (peri_evt[gi]) begin
						flag_ff <= 1'b1;
					end else if (wr_lane0 && hit_pir) begin
						flag_ff <= dat_i[gi];
					end
				end
				assign pir_flag[gi] = flag_ff;
			end
		end
	endgenerate

	// ****************************************
	// Request to the core
	// ****************************************
	logic             core_hit;
	logic             peri_hit;

	assign core_hit = |(core_en_ff[2:0] & core_flag_ff);
	// Group enable is control bit 6, held in core_en_ff[3]
	assign peri_hit = core_en_ff[3] & (|(pie_ff & pir_flag));
	// Flags do not wait for enables, so a stale flag fires at once
	assign core_irq_req_o = core_en_ff[4] & (core_hit | peri_hit);

	// ****************************************
	// Event status and mask
	// ****************************************
	logic [9:0]       evt_raw;
	logic [9:0]       evt_prev_ff;
	logic [9:0]       evt_stat_ff;
	logic [9:0]       evt_mask_ff;

	assign evt_raw = {pir_flag, core_flag_ff};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_prev_ff <= iefc_pkg::RST_EVT;
		end else begin
			evt_prev_ff <= evt_raw;
		end
	end

	// Rising flag sets the sticky bit; set wins over write-one-clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_stat_ff <= iefc_pkg::RST_EVT;
		end else if (wr_lane0 && hit_stat) begin
			evt_stat_ff <= (evt_stat_ff & ~dat_i[9:0]) |
				(evt_raw & ~evt_prev_ff);
		end else begin
			evt_stat_ff <= evt_stat_ff | (evt_raw & ~evt_prev_ff);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_mask_ff <= iefc_pkg::RST_EVT;
		end else if (wr_lane0 && hit_mask) begin
			evt_mask_ff <= dat_i[9:0];
		end
	end

	assign irq_o = |(evt_stat_ff & evt_mask_ff);

	// ****************************************
	// Read data and acknowledge
	// ****************************************
	logic [31:0]      nxt_rd_data;

	always_comb begin
		nxt_rd_data = 32'h0000_0000;
		if (hit_ctrl) begin
			nxt_rd_data[7:0] = {core_en_ff, core_flag_ff};
		end else if (hit_pie) begin
			nxt_rd_data[7:0] = {1'b0, pie_ff};
		end else if (hit_pir) begin
			nxt_rd_data[7:0] = {1'b0, pir_flag};
		end else if (hit_port) begin
			nxt_rd_data[7:0] = {upper_port_nibble_i, 4'h0};
		end else if (hit_stat) begin
			nxt_rd_data[9:0] = evt_stat_ff;
		end else if (hit_mask) begin
			nxt_rd_data[9:0] = evt_mask_ff;
		end
	end

	// Unmapped addresses still ack, reading zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff     <= 1'b0;
			rd_data_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= bus_req;
			if (rd_req) begin
				rd_data_ff <= nxt_rd_data;
			end
		end
	end

	assign ack_o = ack_ff;
	assign dat_o = rd_data_ff;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_flag_timer_set: assert property (
		timer0_overflow_i |=> core_flag_ff[2])
		else $error("timer-0 flag missed its overflow");
	chk_flag_timer_hold: assert property (
		core_flag_ff[2] && !(wr_lane0 && hit_ctrl) |=> core_flag_ff[2])
		else $error("timer-0 flag cleared without a write");
	chk_ext_set: assert property (
		ext_pin_edge_i ##1 !(wr_lane0 && hit_ctrl) |=> core_flag_ff[1])
		else $error("external flag lost");
	chk_port_mismatch: assert property (
		mismatch |=> core_flag_ff[0])
		else $error("port flag not set during mismatch");
	chk_gie_blocks: assert property (
		!core_en_ff[4] |-> !core_irq_req_o)
		else $error("request while global enable is off");
	chk_peripheral_group_enable_gate: assert property (
		!core_en_ff[3] && !core_hit |-> !core_irq_req_o)
		else $error("peripheral request without group enable");
	chk_timer_req: assert property (
		core_en_ff[4] && core_en_ff[2] && core_flag_ff[2]
		|-> core_irq_req_o)
		else $error("enabled timer flag gave no request");
	chk_ext_req: assert property (
		core_en_ff[4] && core_en_ff[1] && core_flag_ff[1]
		|-> core_irq_req_o)
		else $error("enabled external flag gave no request");
	chk_port_req: assert property (
		core_en_ff[4] && core_en_ff[0] && core_flag_ff[0]
		|-> core_irq_req_o)
		else $error("enabled port flag gave no request");
	chk_rx_level: assert property (
		rd_req && hit_pir |=>
		dat_o[5:4] == $past({serial_rx_full_i, serial_tx_empty_i}))
		else $error("serial flags do not follow buffer levels");
	chk_pie_top_zero: assert property (
		rd_req && hit_pie |=> ack_o && dat_o[31:7] == 25'h0)
		else $error("peripheral enable top bits not zero");
	chk_ack_one_cycle: assert property (
		ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
endmodule
`default_nettype wire

/* File: hdl/iefc_pkg.sv */
// Package for the interrupt enable and flag controller.
// Assumes a classic Wishbone slave with 32-bit data and one clock.
`default_nettype none
package iefc_pkg;
	// ****************************************
	// Register indices; byte address is 4x
	// ****************************************
	localparam int          ADR_W          = 11;
	localparam int          IDX_W          = 9;
	localparam logic [8:0]  IDX_CTRL_BANK0 = 9'h00b;
	localparam logic [8:0]  IDX_CTRL_BANK1 = 9'h08b;
	localparam logic [8:0]  IDX_CTRL_BANK2 = 9'h10b;
	localparam logic [8:0]  IDX_CTRL_BANK3 = 9'h18b;
	localparam logic [8:0]  IDX_PIE_ONE    = 9'h08c;
	localparam logic [8:0]  IDX_PIR_ONE    = 9'h00c;
	localparam logic [8:0]  IDX_PORT       = 9'h006;
	localparam logic [8:0]  IDX_EVT_STAT   = 9'h1f0;
	localparam logic [8:0]  IDX_EVT_MASK   = 9'h1f1;
	// ****************************************
	// Core control register fields
	// ****************************************
	localparam int          BIT_GLOBAL_EN  = 7;
	localparam int          BIT_GROUP_EN   = 6;
	localparam int          BIT_T0_EN      = 5;
	localparam int          BIT_EXT_EN     = 4;
	localparam int          BIT_PORT_EN    = 3;
	localparam int          BIT_T0_FLAG    = 2;
	localparam int          BIT_EXT_FLAG   = 1;
	localparam int          BIT_PORT_FLAG  = 0;
	localparam int          PERI_N         = 7;
	localparam int          EVT_N          = 10;
	// Peripheral flags that mirror a buffer level
	localparam logic [6:0]  PIR_LEVEL_MASK = 7'h30;
	localparam int          BIT_RX         = 5;
	localparam int          BIT_TX         = 4;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [4:0]  RST_CORE_EN    = 5'h00;
	localparam logic [2:0]  RST_CORE_FLAG  = 3'h0;
	localparam logic [6:0]  RST_PERI       = 7'h00;
	localparam logic [9:0]  RST_EVT        = 10'h000;
	localparam logic [3:0]  RST_NIBBLE     = 4'h0;
endpackage
`default_nettype wire

/* File: tb/iefc_core_model.sv */
// Processor core model that receives the combined interrupt request.
// Assumes the request is a level that is synchronous to clk_i.
`default_nettype none
module iefc_core_model (
	input  wire logic        clk_i,    // Core clock
	input  wire logic        rst_i,    // Sync reset, high
	input  wire logic        req_i,    // Combined request
	output logic      [15:0] taken_o   // Count of request entries
);
	timeunit 1ns;
	timeprecision 100ps;
	logic req_ff;
	// Counts entries, not levels, so a stuck request shows as one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_ff  <= 1'b0;
			taken_o <= 16'h0000;
		end else begin
			req_ff <= req_i;
			if (req_i && !req_ff) begin
				taken_o <= taken_o + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/interrupt_enable_flag_control_test.sv */
// Testbench for the interrupt enable and flag controller.
// Assumes the Wishbone slave answers with a one-cycle ack.
`default_nettype none
module interrupt_enable_flag_control_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [10:0] adr = 11'h000;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0, dat_o, rd;
	logic        ack_o, core_irq_req_o, irq_o;
	logic [8:0]  ev = 9'h000;
	logic [3:0]  nib = 4'h0;
	logic        rx = 1'b0, tx = 1'b0;
	logic [15:0] taken;
	int          failures = 0, n_checks = 0;

	always #2 clk_i = ~clk_i;

	iefc_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o),
		.ack_o(ack_o), .timer0_overflow_i(ev[7]), .ext_pin_edge_i(ev[8]),
		.upper_port_nibble_i(nib), .converter_done_i(ev[6]),
		.serial_rx_full_i(rx), .serial_tx_empty_i(tx),
		.sync_serial_i(ev[3]), .capcmp_i(ev[2]), .timer2_match_i(ev[1]),
		.timer1_overflow_i(ev[0]), .core_irq_req_o(core_irq_req_o),
		.irq_o(irq_o));
	iefc_core_model u_core (.clk_i(clk_i), .rst_i(rst_i),
		.req_i(core_irq_req_o), .taken_o(taken));

	// ****************************************
	// Bus and check tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [8:0] idx,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1; stb <= 1'b1; we <= w;
		adr <= {idx, 2'b00}; sel <= 4'h1; wdat <= d;
		@(posedge clk_i);
		while (ack_o !== 1'b1 && n < 20) begin
			n++;
			@(posedge clk_i);
		end
		if (n >= 20) chk(32'h1, 32'h0);
		rd = dat_o;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask
	task automatic wr(input logic [8:0] idx, input logic [31:0] d);
		bus(1'b1, idx, d);
	endtask
	task automatic rdchk(input logic [8:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h0);
		chk(rd, exp);
	endtask
	task automatic pulse(input logic [8:0] m);
		@(posedge clk_i);
		ev <= m;
		@(posedge clk_i);
		ev <= 9'h000;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic req(input logic e);
		@(posedge clk_i);
		chk({31'h0, core_irq_req_o}, {31'h0, e});
	endtask
	task automatic report_and_stop;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		#20000;
		failures++;
		report_and_stop();
	end
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rdchk(iefc_pkg::IDX_CTRL_BANK0, 32'h0);
		rdchk(iefc_pkg::IDX_PIE_ONE, 32'h0);
		rdchk(iefc_pkg::IDX_PIR_ONE, 32'h0);
		wr(iefc_pkg::IDX_CTRL_BANK0, 32'h78);
		rdchk(iefc_pkg::IDX_CTRL_BANK1, 32'h78);
		rdchk(iefc_pkg::IDX_CTRL_BANK2, 32'h78);
		rdchk(iefc_pkg::IDX_CTRL_BANK3, 32'h78);
		wr(iefc_pkg::IDX_CTRL_BANK3, 32'h00);
		$display("test banks done");
		pulse(9'h180);
		rdchk(iefc_pkg::IDX_CTRL_BANK0, 32'h06);
		req(1'b0);
		wr(iefc_pkg::IDX_CTRL_BANK0, 32'ha6);
		req(1'b1);
		wr(iefc_pkg::IDX_CTRL_BANK0, 32'h26);
		req(1'b0);
		wr(iefc_pkg::IDX_CTRL_BANK0, 32'h96);
		req(1'b1);
		wr(iefc_pkg::IDX_CTRL_BANK0, 32'h90);
		rdchk(iefc_pkg::IDX_CTRL_BANK0, 32'h90);
		req(1'b0);
		chk({16'h0, taken}, 32'h2);
		$display("test core flags done");
		wr(iefc_pkg::IDX_CTRL_BANK0, 32'h88);
		nib <= 4'ha;
		rdchk(iefc_pkg::IDX_CTRL_BANK0, 32'h89);
		req(1'b1);
		wr(iefc_pkg::IDX_CTRL_BANK0, 32'h88);
		rdchk(iefc_pkg::IDX_CTRL_BANK0, 32'h89);
		rdchk(iefc_pkg::IDX_PORT, 32'ha0);
		wr(iefc_pkg::IDX_CTRL_BANK0, 32'h88);
		rdchk(iefc_pkg::IDX_CTRL_BANK0, 32'h88);
		req(1'b0);
		$display("test port change done");
		wr(iefc_pkg::IDX_CTRL_BANK0, 32'h00);
		wr(iefc_pkg::IDX_PIE_ONE, 32'hff);
		rdchk(iefc_pkg::IDX_PIE_ONE, 32'h7f);
		pulse(9'h04f);
		rx <= 1'b1;
		tx <= 1'b1;
		rdchk(iefc_pkg::IDX_PIR_ONE, 32'h7f);
		wr(iefc_pkg::IDX_CTRL_BANK0, 32'h80);
		req(1'b0);
		wr(iefc_pkg::IDX_CTRL_BANK0, 32'hc0);
		req(1'b1);
		wr(iefc_pkg::IDX_PIR_ONE, 32'h00);
		rdchk(iefc_pkg::IDX_PIR_ONE, 32'h30);
		rx <= 1'b0;
		rdchk(iefc_pkg::IDX_PIR_ONE, 32'h10);
		rdchk(9'h10c, 32'h0);
		$display("test peripherals done");
		wr(iefc_pkg::IDX_EVT_MASK, 32'h008);
		rdchk(iefc_pkg::IDX_EVT_STAT, 32'h3ff);
		chk({31'h0, irq_o}, 32'h1);
		wr(iefc_pkg::IDX_EVT_MASK, 32'h000);
		chk({31'h0, irq_o}, 32'h0);
		wr(iefc_pkg::IDX_EVT_STAT, 32'h3ff);
		wr(iefc_pkg::IDX_EVT_MASK, 32'h3ff);
		rdchk(iefc_pkg::IDX_EVT_STAT, 32'h000);
		chk({31'h0, irq_o}, 32'h0);
		pulse(9'h001);
		chk({31'h0, irq_o}, 32'h1);
		rdchk(9'h100, 32'h0);
		$display("test events done");
		report_and_stop();
	end
endmodule
`default_nettype wire
